// ### verilog/bst_tap.v
// boundary-scan test access port controller and test registers
`timescale 1ns/1ps
`include "bst_map.vh"

module bst_tap (
   // system clock and reset
   input  wire                    clk_i,
   input  wire                    reset_i,
   // test access port pins
   input  wire                    tap_reset_pin_n_i,
   input  wire                    tap_clock_pin_i,
   input  wire                    tap_mode_select_pin_i,
   input  wire                    tap_serial_in_pin_i,
   output wire                    tap_serial_out_pin_o,
   output wire                    tap_serial_out_oe_o,
   // core logic side of the boundary pins
   input  wire [`BST_BSR_MSB:0]   core_data_i,
   input  wire [`BST_BSR_MSB:0]   pin_level_i,
   output wire [`BST_BSR_MSB:0]   pin_data_o,
   output wire                    pin_oe_o,
   // observation
   output wire [`BST_IR_W-1:0]    instr_o,
   output wire                    logic_reset_o
);

   // controller states
   localparam [3:0] ST_TLR  = 4'h0;
   localparam [3:0] ST_RTI  = 4'h1;
   localparam [3:0] ST_SDR  = 4'h2;
   localparam [3:0] ST_CDR  = 4'h3;
   localparam [3:0] ST_SHDR = 4'h4;
   localparam [3:0] ST_E1DR = 4'h5;
   localparam [3:0] ST_PDR  = 4'h6;
   localparam [3:0] ST_E2DR = 4'h7;
   localparam [3:0] ST_UDR  = 4'h8;
   localparam [3:0] ST_SIR  = 4'h9;
   localparam [3:0] ST_CIR  = 4'hA;
   localparam [3:0] ST_SHIR = 4'hB;
   localparam [3:0] ST_E1IR = 4'hC;
   localparam [3:0] ST_PIR  = 4'hD;
   localparam [3:0] ST_E2IR = 4'hE;
   localparam [3:0] ST_UIR  = 4'hF;

   // identification word, one in the lsb
   localparam [`BST_ID_MSB:0] ID_WORD =
      {`BST_ID_VER, `BST_ID_PART, `BST_ID_MFR, `BST_ID_ONE};

   // reset chain: asserted at once, released on clk_i
   reg  [1:0]               rst_sync_reg;
   wire                     rst_async;
   wire                     tap_rst;
   // pin synchronisers, two stages each
   reg  [1:0]               tck_sync_reg;
   reg                      tck_prev_reg;
   reg  [1:0]               tms_sync_reg;
   reg  [1:0]               tdi_sync_reg;
   reg  [`BST_BSR_MSB:0]    pin_meta_reg;
   reg  [`BST_BSR_MSB:0]    pin_sync_reg;
   // test clock edges seen on clk_i
   wire                     tck_rise;
   wire                     tck_fall;
   wire                     tms;
   wire                     tdi;
   // controller state
   reg  [`BST_ST_W-1:0]     state_reg;
   reg  [`BST_ST_W-1:0]     state_next;
   // instruction shift and latch
   reg  [`BST_IR_W-1:0]     ir_shift_reg;
   reg  [`BST_IR_W-1:0]     ir_reg;
   // data registers
   reg                      byp_reg;
   reg  [`BST_ID_MSB:0]     id_shift_reg;
   reg  [`BST_BSR_MSB:0]    bsr_shift_reg;
   reg  [`BST_BSR_MSB:0]    bsr_latch_reg;
   // serial output stage
   reg                      tdo_reg;
   reg                      tdo_oe_reg;
   reg                      tdo_next;
   // instruction decode
   wire                     sel_bsr;
   wire                     sel_id;
   wire                     sel_byp;
   wire                     drive_bsr;

   // test reset pin acts asynchronously on the tap
   assign rst_async = reset_i | ~tap_reset_pin_n_i;

   // reset synchroniser, constant loads only
   always @(posedge clk_i or posedge rst_async) begin
      if (rst_async) begin
         rst_sync_reg <= 2'h3;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'h0};
      end
   end

   // tap reset stays high until two clean edges
   assign tap_rst = rst_sync_reg[1];

   // sample all pin inputs but the test reset through two flops
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tck_sync_reg <= 2'h0;
         tck_prev_reg <= 1'h0;
         tms_sync_reg <= 2'h3;
         tdi_sync_reg <= 2'h3;
         pin_meta_reg <= {`BST_BSR_W{1'h0}};
         pin_sync_reg <= {`BST_BSR_W{1'h0}};
      end else begin
         tck_sync_reg <= {tck_sync_reg[0], tap_clock_pin_i};
         tck_prev_reg <= tck_sync_reg[1];
         tms_sync_reg <= {tms_sync_reg[0], tap_mode_select_pin_i};
         tdi_sync_reg <= {tdi_sync_reg[0], tap_serial_in_pin_i};
         pin_meta_reg <= pin_level_i;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // edges of the test clock, from second stage only
   assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
   assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;
   assign tms      = tms_sync_reg[1];
   assign tdi      = tdi_sync_reg[1];

   // instruction decode
   assign sel_bsr = (ir_reg == `BST_IR_EXTEST) |
                    (ir_reg == `BST_IR_SAMPLE);
   assign sel_id  = (ir_reg == `BST_IR_IDCODE);
   // clamp, highz, bypass and unused codes take the bypass stage
   assign sel_byp = ~sel_bsr & ~sel_id;
   // extest and clamp drive the latched cells onto the pins
   assign drive_bsr = (ir_reg == `BST_IR_EXTEST) |
                      (ir_reg == `BST_IR_CLAMP);

   // next state from mode select level
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_TLR:  state_next = tms ? ST_TLR  : ST_RTI;
         ST_RTI:  state_next = tms ? ST_SDR  : ST_RTI;
         ST_SDR:  state_next = tms ? ST_SIR  : ST_CDR;
         ST_CDR:  state_next = tms ? ST_E1DR : ST_SHDR;
         ST_SHDR: state_next = tms ? ST_E1DR : ST_SHDR;
         ST_E1DR: state_next = tms ? ST_UDR  : ST_PDR;
         ST_PDR:  state_next = tms ? ST_E2DR : ST_PDR;
         ST_E2DR: state_next = tms ? ST_UDR  : ST_SHDR;
         ST_UDR:  state_next = tms ? ST_SDR  : ST_RTI;
         ST_SIR:  state_next = tms ? ST_TLR  : ST_CIR;
         ST_CIR:  state_next = tms ? ST_E1IR : ST_SHIR;
         ST_SHIR: state_next = tms ? ST_E1IR : ST_SHIR;
         ST_E1IR: state_next = tms ? ST_UIR  : ST_PIR;
         ST_PIR:  state_next = tms ? ST_E2IR : ST_PIR;
         // inverted sense kept as the device behaves
         ST_E2IR: state_next = tms ? ST_SHIR : ST_UIR;
         ST_UIR:  state_next = tms ? ST_SDR  : ST_RTI;
         default: state_next = ST_TLR;
      endcase
   end

   // state register moves only on a test clock rise
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         state_reg <= ST_TLR;
      end else if (tck_rise) begin
         state_reg <= state_next;
      end
   end

   // instruction shift path, rising edges
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         ir_shift_reg <= `BST_IR_CAPT;
      end else if (tck_rise) begin
         case (state_reg)
            // fixed pattern with ones-zero in the low bits
            ST_CIR:  ir_shift_reg <= `BST_IR_CAPT;
            // lsb leaves first, tdi enters at the msb
            ST_SHIR: ir_shift_reg <= {tdi, ir_shift_reg[`BST_IR_W-1:1]};
            default: ir_shift_reg <= ir_shift_reg;
         endcase
      end
   end

   // instruction latch, falling edges
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         ir_reg <= `BST_IR_IDCODE;
      end else if (state_reg == ST_TLR) begin
         // identification forced while in reset state
         ir_reg <= `BST_IR_IDCODE;
      end else if (tck_fall && state_reg == ST_UIR) begin
         ir_reg <= ir_shift_reg;
      end
   end

   // bypass stage
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         byp_reg <= 1'h0;
      end else if (tck_rise && sel_byp) begin
         if (state_reg == ST_CDR) begin
            byp_reg <= 1'h0;
         end else if (state_reg == ST_SHDR) begin
            byp_reg <= tdi;
         end
      end
   end

   // identification shift register
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         id_shift_reg <= ID_WORD;
      end else if (tck_rise && sel_id) begin
         if (state_reg == ST_CDR) begin
            id_shift_reg <= ID_WORD;
         end else if (state_reg == ST_SHDR) begin
            id_shift_reg <= {tdi, id_shift_reg[`BST_ID_MSB:1]};
         end
      end
   end

   // boundary shift path, captures the pin levels
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         bsr_shift_reg <= {`BST_BSR_W{1'h0}};
      end else if (tck_rise && sel_bsr) begin
         if (state_reg == ST_CDR) begin
            bsr_shift_reg <= pin_sync_reg;
         end else if (state_reg == ST_SHDR) begin
            bsr_shift_reg <= {tdi, bsr_shift_reg[`BST_BSR_MSB:1]};
         end
      end
   end

   // boundary output latch, falling edge in update-DR
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         bsr_latch_reg <= {`BST_BSR_W{1'h0}};
      end else if (tck_fall && state_reg == ST_UDR && sel_bsr) begin
         bsr_latch_reg <= bsr_shift_reg;
      end
   end

   // serial output bit of the selected path
   always @* begin
      tdo_next = byp_reg;
      if (state_reg == ST_SHIR) begin
         tdo_next = ir_shift_reg[0];
      end else if (sel_bsr) begin
         tdo_next = bsr_shift_reg[0];
      end else if (sel_id) begin
         tdo_next = id_shift_reg[`BST_ID_LSB];
      end
   end

   // output changes on falling edges, driven only while shifting
   always @(posedge clk_i or posedge tap_rst) begin
      if (tap_rst) begin
         tdo_reg    <= 1'h0;
         tdo_oe_reg <= 1'h0;
      end else if (tck_fall) begin
         tdo_reg    <= tdo_next;
         tdo_oe_reg <= (state_reg == ST_SHIR) | (state_reg == ST_SHDR);
      end
   end

   // serial pin; a stopped clock leaves every flop but the pin synchronisers unchanged
   assign tap_serial_out_pin_o = tdo_reg;
   assign tap_serial_out_oe_o  = tdo_oe_reg;

   // system pins: core passes through unless a test drives them
   assign pin_data_o = drive_bsr ? bsr_latch_reg : core_data_i;
   assign pin_oe_o   = (ir_reg != `BST_IR_HIGHZ);

   // observation outputs
   assign instr_o       = ir_reg;
   assign logic_reset_o = (state_reg == ST_TLR);

   // register set: instruction, bypass, boundary, identification
   // all four sit on the serial output mux above

endmodule // bst_tap

// ### verilog/bst_map.vh
// constants for the boundary-scan test access port
`ifndef BST_MAP_VH
`define BST_MAP_VH

// instruction register
`define BST_IR_W       3
`define BST_IR_EXTEST  3'h0
`define BST_IR_IDCODE  3'h1
`define BST_IR_SAMPLE  3'h2
`define BST_IR_CLAMP   3'h3
`define BST_IR_HIGHZ   3'h4
`define BST_IR_BYPASS  3'h7
`define BST_IR_CAPT    3'h1

// data registers
`define BST_ID_W       32
`define BST_ID_LSB     0
`define BST_BSR_W      8
`define BST_BSR_MSB    7
`define BST_ID_MSB     31

// identification code fields, values arbitrary
`define BST_ID_VER     4'h5
`define BST_ID_PART    16'h0ABC
`define BST_ID_MFR     11'h123
`define BST_ID_ONE     1'h1

// controller state width
`define BST_ST_W       4

`endif

// ### dv/bst_tap_monitor.sv
// concurrent checks on the tap controller ports
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_tap_monitor (
   // clock and reset
   input wire                  clk_i,
   input wire                  reset_i,
   input wire                  tap_reset_pin_n_i,
   // test pins
   input wire                  tap_clock_pin_i,
   input wire                  tap_serial_out_pin_o,
   input wire                  tap_serial_out_oe_o,
   // core side and observation
   input wire [`BST_BSR_MSB:0] core_data_i,
   input wire [`BST_BSR_MSB:0] pin_data_o,
   input wire                  pin_oe_o,
   input wire [`BST_IR_W-1:0]  instr_o,
   input wire                  logic_reset_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // test clock held still for a while
   sequence s_still;
      $stable(tap_clock_pin_i) [*8];
   endsequence
   // two cycles in reset state
   sequence s_tlr;
      logic_reset_o ##1 logic_reset_o;
   endsequence
   chk_reset_idcode: assert property (s_tlr |-> instr_o == `BST_IR_IDCODE)
      else $error("instruction not idcode in reset state");
   chk_reset_quiet: assert property (s_tlr |-> !tap_serial_out_oe_o)
      else $error("serial out driven in reset state");
   chk_trst_async: assert property (!tap_reset_pin_n_i |=> logic_reset_o)
      else $error("test reset did not reach reset state");
   chk_highz_oe: assert property (pin_oe_o == (instr_o != `BST_IR_HIGHZ))
      else $error("pin enable wrong for instruction");
   chk_core_pass: assert property ((instr_o != `BST_IR_EXTEST && instr_o != `BST_IR_CLAMP)
      |-> pin_data_o == core_data_i)
      else $error("core data not passed to pins");
   chk_instr_fall: assert property ($changed(instr_o) && !logic_reset_o
      |-> !tap_clock_pin_i)
      else $error("instruction changed outside low clock phase");
   chk_oe_fall: assert property ($rose(tap_serial_out_oe_o) |-> !tap_clock_pin_i)
      else $error("serial out enabled outside low clock phase");
   chk_stop_hold: assert property (@(posedge clk_i) disable iff (reset_i || !tap_reset_pin_n_i)
      s_still |-> $stable(instr_o) && $stable(logic_reset_o)
      && $stable(tap_serial_out_pin_o))
      else $error("state moved with test clock stopped");
endmodule // bst_tap_monitor
bind bst_tap bst_tap_monitor i_mon (.clk_i(clk_i), .reset_i(reset_i),
   .tap_reset_pin_n_i(tap_reset_pin_n_i), .tap_clock_pin_i(tap_clock_pin_i),
   .tap_serial_out_pin_o(tap_serial_out_pin_o), .tap_serial_out_oe_o(tap_serial_out_oe_o),
   .core_data_i(core_data_i), .pin_data_o(pin_data_o), .pin_oe_o(pin_oe_o),
   .instr_o(instr_o), .logic_reset_o(logic_reset_o));

// ### dv/bst_tester.sv
// behavioural external test controller driving the tap pins
`timescale 1ns/1ps
module bst_tester (
   // clock
   input  wire clk_i,
   // tap pins
   output reg  tck_o,
   output reg  tms_o,
   output reg  tdi_o,
   input  wire tdo_i,
   input  wire tdo_oe_i
);
   // test clock idles low before the first frame
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // one 64 ns period: fall with new data, rise, take tdo; stops high after
   task bit_cyc(input logic tms, input logic tdi, output logic tdo);
      begin
         tck_o <= 1'b0;
         tms_o <= tms;
         tdi_o <= tdi;
         repeat (4) @(posedge clk_i);
         tck_o <= 1'b1;
         @(posedge clk_i);
         // released line reads as the inverse
         tdo = tdo_oe_i ? tdo_i : ~tdo_i;
         repeat (3) @(posedge clk_i);
      end
   endtask
endmodule // bst_tester

// ### dv/tb.sv
// testbench for the boundary-scan tap controller
`timescale 1ns/1ps
`include "bst_map.vh"
module tb;
   logic        clk_i = 1'b0;     // system clock
   logic        reset_i = 1'b1;   // system reset
   logic        trst_n = 1'b1;    // test reset, active low
   logic [7:0]  core = 8'h96;     // core pin values
   logic [7:0]  level = 8'h5A;    // pin levels
   wire         tck, tms, tdi, tdo, oe, pin_oe, lrst;
   wire  [7:0]  pin_data;
   wire  [2:0]  instr;
   logic [31:0] d;
   logic        t;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   bst_tap i_bst_tap (.clk_i(clk_i), .reset_i(reset_i), .tap_reset_pin_n_i(trst_n),
      .tap_clock_pin_i(tck), .tap_mode_select_pin_i(tms), .tap_serial_in_pin_i(tdi),
      .tap_serial_out_pin_o(tdo), .tap_serial_out_oe_o(oe), .core_data_i(core),
      .pin_level_i(level), .pin_data_o(pin_data), .pin_oe_o(pin_oe), .instr_o(instr),
      .logic_reset_o(lrst));
   bst_tester u_tester (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .tdo_i(tdo), .tdo_oe_i(oe));
   // free-running system clock
   initial forever #4 clk_i = ~clk_i;
   // compare and count
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      begin
         total_checks++;
         if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // verdict and end of run
   task results;
      begin
         $display("checks %0d errors %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // one test clock with wait for the state to land
   task step(input logic m);
      begin
         u_tester.bit_cyc(m, 1'b0, t);
         repeat (6) @(posedge clk_i);
      end
   endtask
   // full scan from run-test-idle, lsb first, back to idle
   task scan(input logic ir, input int n, input logic [31:0] din);
      begin
         d = '0;
         u_tester.bit_cyc(1'b1, 1'b0, t);
         if (ir)
            u_tester.bit_cyc(1'b1, 1'b0, t);
         u_tester.bit_cyc(1'b0, 1'b0, t);
         u_tester.bit_cyc(1'b0, 1'b0, t);
         for (int i = 0; i < n; i++) begin
            u_tester.bit_cyc(i == n - 1, din[i], t);
            d[i] = t;
         end
         u_tester.bit_cyc(1'b1, 1'b0, t);
         u_tester.bit_cyc(1'b0, 1'b0, t);
      end
   endtask
   // instruction walk through extest, clamp, bypass and sample and their data registers
   task t_instr;
      begin
         scan(1'b1, 3, `BST_IR_EXTEST);
         check("ir capture", d, `BST_IR_CAPT);
         check("extest", instr, `BST_IR_EXTEST);
         scan(1'b0, 8, 32'hC3);
         check("pin capture", d, level);
         check("pins driven", pin_data, 8'hC3);
         step(1'b0);
         check("idle holds", pin_data, 8'hC3);
         scan(1'b1, 3, `BST_IR_CLAMP);
         check("clamp pins", pin_data, 8'hC3);
         scan(1'b0, 2, 32'h1);
         check("clamp bypass", d, 32'h2);
         scan(1'b1, 3, `BST_IR_BYPASS);
         check("bypass", instr, `BST_IR_BYPASS);
         scan(1'b0, 4, 32'hB);
         check("bypass path", d, 32'h6);
         scan(1'b1, 3, `BST_IR_SAMPLE);
         check("sample pins", pin_data, core);
         scan(1'b0, 8, 32'h0);
         check("sample capture", d, level);
      end
   endtask
   // instruction path through pause and the reversed exit2 branch
   task t_exit2;
      logic [11:0] ms;
      logic [11:0] di;
      begin
         ms = 12'h243;
         di = 12'h040;
         for (int i = 0; i < 12; i++)
            u_tester.bit_cyc(ms[i], di[i], t);
         check("exit2 update", instr, `BST_IR_HIGHZ);
         check("highz oe", pin_oe, 1'b0);
      end
   endtask
   // async test reset in mid-shift, then tms walks
   task t_trst;
      begin
         step(1'b1);
         step(1'b0);
         step(1'b0);
         step(1'b0);
         @(posedge clk_i);
         trst_n <= 1'b0;
         // hold the test reset past its minimum low width
         repeat (13) @(posedge clk_i);
         check("trst state", lrst, 1'b1);
         check("trst instr", instr, `BST_IR_IDCODE);
         trst_n <= 1'b1;
         repeat (8) @(posedge clk_i);
         step(1'b0);
         check("leave reset", lrst, 1'b0);
         step(1'b1);
         step(1'b1);
         step(1'b1);
         check("selir reset", lrst, 1'b1);
      end
   endtask
   // hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         results;
      end
   end
   // power-up state, first steps and identification scan
   task t_power;
      begin
         repeat (8) @(posedge clk_i);
         check("power-up state", lrst, 1'b1);
         check("power-up instr", instr, `BST_IR_IDCODE);
         step(1'b1);
         check("tlr stays", lrst, 1'b1);
         step(1'b0);
         check("to idle", lrst, 1'b0);
         step(1'b0);
         check("idle stays", lrst, 1'b0);
         scan(1'b0, 32, 32'h0);
         check("idcode", d, {`BST_ID_VER, `BST_ID_PART, `BST_ID_MFR, `BST_ID_ONE});
      end
   endtask
   // bypass data path through pause-DR and back to shift via exit2-DR
   task t_pause_dr;
      logic [11:0] ms;
      logic [11:0] di;
      logic [11:0] so;
      begin
         ms = 12'h691;
         di = 12'h018;
         so = '0;
         for (int i = 0; i < 12; i++) begin
            u_tester.bit_cyc(ms[i], di[i], t);
            so[i] = t;
         end
         check("bypass capture", so[3], 1'b0);
         check("pause holds", so[9], 1'b1);
      end
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      t_power;
      t_instr;
      t_exit2;
      t_pause_dr;
      t_trst;
      results;
   end
endmodule // tb
